//--- cmss_pkg.sv
// Package for the comparator mask source selector.
// Assumes a 32-bit APB register bus; one register at a chosen offset.
package cmss_pkg;

  // Register map.
  localparam logic [11:0] CMSS_SEL_OFFSET     = 12'h000;
  localparam logic [15:0] CMSS_SEL_RESET      = 16'h0000;
  localparam logic [15:0] CMSS_SEL_WR_MASK    = 16'h0FFF;

  // Field positions inside the select register.
  localparam int          CMSS_FIELD_W        = 4;
  localparam int          CMSS_A_LSB          = 0;
  localparam int          CMSS_B_LSB          = 4;
  localparam int          CMSS_C_LSB          = 8;

  // Source codes shared by all three fields.
  localparam logic [3:0]  CMSS_SRC_PWM_GEN1_LOW      = 4'h0;
  localparam logic [3:0]  CMSS_SRC_PWM_GEN1_HIGH      = 4'h1;
  localparam logic [3:0]  CMSS_SRC_PWM_GEN2_LOW      = 4'h2;
  localparam logic [3:0]  CMSS_SRC_PWM_GEN2_HIGH      = 4'h3;
  localparam logic [3:0]  CMSS_SRC_PWM_GEN3_LOW      = 4'h4;
  localparam logic [3:0]  CMSS_SRC_PWM_GEN3_HIGH      = 4'h5;
  localparam logic [3:0]  CMSS_SRC_SEQ18      = 4'hC;
  localparam logic [3:0]  CMSS_SRC_SEQ19      = 4'hD;
  localparam logic [3:0]  CMSS_SRC_FAULT2     = 4'hE;
  localparam logic [3:0]  CMSS_SRC_FAULT4     = 4'hF;

endpackage

//--- cmss_src_model.sv
// Model of the source nets: ten levels that shift along one place every cycle.
// Assumes the selector's clock.
`timescale 1ns/1ns
module cmss_src_model (
  // Clock
  input  wire logic       i_core_clk,
  // Bit 0 is pwm_gen1_low, bit 9 fault_input_4
  output logic      [9:0] o_src
);
  initial o_src = 10'h2B5;
  // A shift pattern keeps the ten sources distinct from one another.
  always @(posedge i_core_clk) o_src <= {o_src[8:0], o_src[9] ^ o_src[6]};
endmodule

//--- cmss_top.sv
// Comparator mask source selector: APB register and three source muxes.
// Assumes the source nets are synchronous to i_core_clk.
//
// Function
// - Bits 15 to 12 read as zero; writes to them are ignored.
// - Field C codes 0 to 5 pick PWM generators 1 to 3 low/high.
// - Codes C to F pick sequencer 18, 19, fault 2, fault 4; rest reserved.
// - Field B in bits 7 to 4 uses the same code map as field C.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module cmss_top (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Candidate mask sources
  input  wire logic        i_pwm_gen1_low,
  input  wire logic        i_pwm_gen1_high,
  input  wire logic        i_pwm_gen2_low,
  input  wire logic        i_pwm_gen2_high,
  input  wire logic        i_pwm_gen3_low,
  input  wire logic        i_pwm_gen3_high,
  input  wire logic        i_sequencer_output_18,
  input  wire logic        i_sequencer_output_19,
  input  wire logic        i_fault_input_2,
  input  wire logic        i_fault_input_4,
  // Selected mask inputs
  output logic             o_mask_a,
  output logic             o_mask_b,
  output logic             o_mask_c
);
  import cmss_pkg::*;

  typedef enum logic [1:0] {
    CMSS_BUS_IDLE   = 2'h1,
    CMSS_BUS_ANSWER = 2'h2
  } cmss_bus_state_t;

  cmss_bus_state_t bus_state_reg;
  cmss_bus_state_t bus_state_next;
  logic            rst_n;
  logic [15:0]     sel_reg;
  logic [15:0]     sel_next;
  logic [31:0]     prdata_reg;
  logic [31:0]     prdata_next;
  logic            pready_reg;
  logic            pready_next;
  logic            pslverr_reg;
  logic            pslverr_next;
  logic [9:0]      src_vec;
  logic [2:0]      mask_vec;
  logic [15:0]     rd_word;
  logic            hit;
  logic            setup;
  logic            access;
  logic            wr_commit;

  // The rest of the block sees only the retimed reset.
  cmss_rst_sync cmss_rst_sync_inst (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .o_rst_n    (rst_n)
  );

  // No wait state: the answer is prepared in the setup cycle so that
  // pready can come from a flop and still close the access cycle.
  assign setup     = i_psel & ~i_penable;
  assign access    = i_psel & i_penable;
  assign hit       = (i_paddr[11:2] == CMSS_SEL_OFFSET[11:2]);
  assign wr_commit = access & i_pwrite & hit &
                     (bus_state_reg == CMSS_BUS_ANSWER);

  // Bus phase: the cycle after a setup is the answer cycle, the only one
  // in which a write may land. It runs in step with pready.
  always_comb begin
    bus_state_next = CMSS_BUS_IDLE;
    case (bus_state_reg)
      CMSS_BUS_IDLE: begin
        if (setup) begin
          bus_state_next = CMSS_BUS_ANSWER;
        end
      end
      CMSS_BUS_ANSWER: begin
        if (setup) begin
          bus_state_next = CMSS_BUS_ANSWER;
        end
      end
      default: begin
        bus_state_next = CMSS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= CMSS_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Unimplemented upper bits are cleared on the way out as well as on
  // the way in, so a read can never show them set.
  assign rd_word = sel_reg & CMSS_SEL_WR_MASK;

  // Select register: only a committed write to the mapped word moves it.
  always_comb begin
    sel_next = sel_reg;
    if (wr_commit) begin
      sel_next = i_pwdata[15:0] & CMSS_SEL_WR_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= CMSS_SEL_RESET;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // Bus response: ready, error and read data, all launched from flops.
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = 1'h0;
    pslverr_next = 1'h0;
    if (setup) begin
      pready_next  = 1'h1;
      pslverr_next = ~hit;
      prdata_next  = 32'h0000_0000;
      if (hit && !i_pwrite) begin
        prdata_next = {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Candidate sources in code order: bit 0 answers code 0, bits 6 to 9 codes C to F.
  assign src_vec = {i_fault_input_4,
                    i_fault_input_2,
                    i_sequencer_output_19,
                    i_sequencer_output_18,
                    i_pwm_gen3_high,
                    i_pwm_gen3_low,
                    i_pwm_gen2_high,
                    i_pwm_gen2_low,
                    i_pwm_gen1_high,
                    i_pwm_gen1_low};

  // One selector per field: index 0 drives mask A, 1 mask B, 2 mask C.
  // All three share one code map, so one selector module serves them all.
  for (genvar g = 0; g < 3; g++) begin : g_mask
    localparam int LSB = (g == 0) ? CMSS_A_LSB :
                         (g == 1) ? CMSS_B_LSB : CMSS_C_LSB;
    cmss_src_mux #(
      .CODE_W (CMSS_FIELD_W),
      .SRC_N  (10)
    ) cmss_src_mux_inst (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_code     (sel_reg[LSB +: CMSS_FIELD_W]),
      .i_src      (src_vec),
      .o_mask     (mask_vec[g])
    );
  end

  // Every output leaves straight from a flop.
  assign o_prdata  = prdata_reg;
  assign o_pready  = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_mask_a  = mask_vec[0];
  assign o_mask_b  = mask_vec[1];
  assign o_mask_c  = mask_vec[2];

endmodule

// Reset release: assertion reaches every flop at once, while release is
// retimed by two flops so that no flop leaves reset close to a clock edge.
// Hold the raw reset low for at least one rising edge.
module cmss_rst_sync (
  // Clock and raw reset
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  // Retimed reset
  output logic      o_rst_n
);
  import cmss_pkg::*;

  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  always_comb begin
    sync_next = {sync_reg[0], 1'h1};
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Only the second flop leaves the synchroniser; the first may still be
  // settling when it is sampled.
  assign o_rst_n = sync_reg[1];

endmodule

// One source selector: decodes a source code and registers the chosen
// level, so each mask input is driven straight from a flop.
module cmss_src_mux #(
  parameter int CODE_W = 4,
  parameter int SRC_N  = 10
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // Source code and candidate levels
  input  wire logic [CODE_W-1:0] i_code,
  input  wire logic [SRC_N-1:0]  i_src,
  // Selected level
  output logic                   o_mask
);
  import cmss_pkg::*;

  logic mask_reg;
  logic mask_next;

  // Reserved codes fall to the default and give a quiet low, so a stray
  // code leaves the mask input inactive instead of following a neighbour.
  always_comb begin
    mask_next = 1'h0;
    case (i_code)
      CMSS_SRC_PWM_GEN1_LOW: begin
        mask_next = i_src[0];
      end
      CMSS_SRC_PWM_GEN1_HIGH: begin
        mask_next = i_src[1];
      end
      CMSS_SRC_PWM_GEN2_LOW: begin
        mask_next = i_src[2];
      end
      CMSS_SRC_PWM_GEN2_HIGH: begin
        mask_next = i_src[3];
      end
      CMSS_SRC_PWM_GEN3_LOW: begin
        mask_next = i_src[4];
      end
      CMSS_SRC_PWM_GEN3_HIGH: begin
        mask_next = i_src[5];
      end
      CMSS_SRC_SEQ18: begin
        mask_next = i_src[6];
      end
      CMSS_SRC_SEQ19: begin
        mask_next = i_src[7];
      end
      CMSS_SRC_FAULT2: begin
        mask_next = i_src[8];
      end
      CMSS_SRC_FAULT4: begin
        mask_next = i_src[9];
      end
      default: begin
        mask_next = 1'h0;
      end
    endcase
  end

  // The chosen level is registered, so each mask lags its source by one
  // clock; rewriting a code therefore never glitches the mask input.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= 1'h0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign o_mask = mask_reg;

endmodule

//--- cmss_top_properties.sv
// APB checker for the mask source selector.
// Assumes binding onto cmss_top.
`timescale 1ns/1ns
module cmss_top_properties (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_ans; i_psel && !i_penable |=> o_pready; endproperty
  property p_one; o_pready |=> !o_pready; endproperty
  property p_idle; !i_psel |=> !o_pready; endproperty
  property p_err; o_pready |-> o_pslverr == (i_paddr[11:2] != 10'h000);
  endproperty
  property p_hi; o_pready |-> o_prdata[31:12] == 20'h00000; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  a_one: assert property (p_one) else $error("long answer");
  a_idle: assert property (p_idle) else $error("stray answer");
  a_err: assert property (p_err) else $error("bad error flag");
  a_hi: assert property (p_hi) else $error("upper bits set");
  c_ok: cover property (o_pready && !o_pslverr);
  c_err: cover property (o_pready && o_pslverr);
  c_two: cover property (o_pready ##2 o_pready);
endmodule
bind cmss_top cmss_top_properties cmss_top_properties_inst (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr));

//--- tb_comparator_mask_source_mux.sv
// Bench for register access and mask routing of the selector.
// Assumes the source model and the checker are compiled first.
`timescale 1ns/1ns
module tb_comparator_mask_source_mux;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    n_fail++; $display("mismatch %0t bad value", $time); end end
  logic        clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0;
  logic        rdy, err, e, pa, pb, pc;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rd, q;
  logic [9:0]  s, p;
  logic [3:0]  cd [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hC, 4'hD,
                           4'hE, 4'hF};
  int          n_fail = 0, total_checks = 0;
  always #10 clk = ~clk;
  // Masks lag the sources by one cycle, so keep last cycle's levels.
  always @(posedge clk) p <= s;
  cmss_src_model cmss_src_model_inst (.i_core_clk(clk), .o_src(s));
  cmss_top cmss_top_inst (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd),
    .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .i_pwm_gen1_low(s[0]), .i_pwm_gen1_high(s[1]), .i_pwm_gen2_low(s[2]),
    .i_pwm_gen2_high(s[3]), .i_pwm_gen3_low(s[4]), .i_pwm_gen3_high(s[5]),
    .i_sequencer_output_18(s[6]), .i_sequencer_output_19(s[7]),
    .i_fault_input_2(s[8]), .i_fault_input_4(s[9]),
    .o_mask_a(pa), .o_mask_b(pb), .o_mask_c(pc));
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    en <= 1'b0;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rd;
    e = err;
    sel <= 1'b0;
    en <= 1'b0;
  endtask
  task automatic t_reg;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0000_0000)
    `CHK(e, 1'b0)
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0000_0FFF)
    apb(1'b1, 12'h004, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0000_0FFF)
  endtask
  task automatic t_map;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 12'h000, {20'h0, cd[i], cd[(i+1)%10], cd[(i+2)%10]});
      repeat (3) @(negedge clk);
      for (int k = 0; k < 8; k++) begin
        @(negedge clk);
        `CHK(pc, p[i])
        `CHK(pb, p[(i+1)%10])
        `CHK(pa, p[(i+2)%10])
      end
    end
  endtask
  // Reserved codes must leave every mask input low.
  task automatic t_rsv;
    for (int c = 6; c < 12; c++) begin
      apb(1'b1, 12'h000, {20'h0, 4'(c), 4'(c), 4'(c)});
      repeat (3) @(negedge clk);
      for (int k = 0; k < 4; k++) begin
        @(negedge clk);
        `CHK(pc, 1'b0)
        `CHK(pb, 1'b0)
        `CHK(pa, 1'b0)
      end
    end
  endtask
  // A reset in mid-run clears all fields, so every mask follows code 0.
  task automatic t_rst;
    apb(1'b1, 12'h000, 32'h0000_0ABC);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(pc, 1'b0)
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(pa, p[0])
    `CHK(pb, p[0])
    `CHK(pc, p[0])
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0000_0000)
    `CHK(e, 1'b0)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reg();
    t_map();
    t_rsv();
    t_rst();
    close_out();
  end
  initial begin
    #60000;
    n_fail++;
    close_out();
  end
endmodule
